/* File: hdl/lps_sensor_regs.sv */
// Purpose: Serial target, register bank and conversion timing of the sensor
// Assumes: Front-end raw samples are on mclk; bus pins are asynchronous
// Notes:   Bus pins are oversampled by mclk; open-drain pins drive low only
`timescale 1ns/1ps
`default_nettype none
module lps_sensor_regs
	import lps_pkg::*;
#(
	parameter int         LIGHT_CYC  = LIGHT_CONV_CYC,
	parameter int         PROX_CYC   = PROX_CONV_CYC,
	parameter int         SLEEP_CYC  = SLEEP_UNIT_CYC,
	parameter logic [7:0] PRODUCT_IDENTIFICATION = PRODUCT_IDENTIFICATION_DEF
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// Serial bus pins
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output var  logic        sda_o,
	output var  logic        sda_oe,
	// Open-drain alert line
	output var  logic        alert_line_n_o,
	output var  logic        alert_line_n_oe,
	// Analog front end
	input  wire logic [15:0] light_raw,
	input  wire logic [9:0]  prox_raw,
	output var  logic [2:0]  light_span_select,
	output var  logic        emitter_drive_select,
	output var  logic        emitter_pulse
);
	// Sleep code to gap in 12.5 ms units
	function automatic logic [6:0] gap_units(input logic [2:0] code);
		case (code)
			3'h7: gap_units = 7'h00;
			3'h6: gap_units = 7'h01;
			3'h5: gap_units = 7'h04;
			3'h4: gap_units = 7'h06;
			3'h3: gap_units = 7'h08;
			3'h2: gap_units = 7'h10;
			3'h1: gap_units = 7'h20;
			default: gap_units = 7'h40;
		endcase
	endfunction : gap_units

	// Persistence code to consecutive trips needed
	function automatic logic [4:0] need_trips(input logic [1:0] code);
		case (code)
			2'h0: need_trips = 5'h01;
			2'h1: need_trips = 5'h04;
			2'h2: need_trips = 5'h08;
			default: need_trips = 5'h10;
		endcase
	endfunction : need_trips

	// Next persistence count; saturates so it never wraps
	function automatic logic [4:0] pers_next(input logic trip,
		input logic [4:0] cnt);
		pers_next = !trip ? 5'h00 : (cnt == 5'h1f) ? cnt : 5'(cnt + 5'h01);
	endfunction : pers_next

	// Pin synchronisers and one stage of history
	logic [1:0] scl_sync_ff, sda_sync_ff;
	logic       scl_q_ff,    sda_q_ff;
	logic [1:0] nxt_scl_sync, nxt_sda_sync;

	// Sync stage one feeds only stage two
	always_comb begin
		nxt_scl_sync = {scl_sync_ff[0], scl_i};
		nxt_sda_sync = {sda_sync_ff[0], sda_i};
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_q_ff    <= 1'h1;
			sda_q_ff    <= 1'h1;
		end else begin
			scl_sync_ff <= nxt_scl_sync;
			sda_sync_ff <= nxt_sda_sync;
			scl_q_ff    <= scl_sync_ff[1];
			sda_q_ff    <= sda_sync_ff[1];
		end
	end

	// Bus events seen on the clean copies
	logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_s     = scl_sync_ff[1];
	assign sda_s     = sda_sync_ff[1];
	assign scl_rise  = !scl_q_ff && scl_s;
	assign scl_fall  = scl_q_ff && !scl_s;
	assign bus_start = scl_s && scl_q_ff && sda_q_ff && !sda_s;
	assign bus_stop  = scl_s && scl_q_ff && !sda_q_ff && sda_s;

	// Serial target states
	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_ADDR  = 7'b0000010,
		ST_AACK  = 7'b0000100,
		ST_WDATA = 7'b0001000,
		ST_WACK  = 7'b0010000,
		ST_RDATA = 7'b0100000,
		ST_RACK  = 7'b1000000
	} lps_bus_st_t;

	lps_bus_st_t st_ff, nxt_st;
	logic [7:0]  shift_ff, nxt_shift;  // Receive or transmit byte
	logic [3:0]  bits_ff,  nxt_bits;   // Bits moved in this byte
	logic [7:0]  ptr_ff,   nxt_ptr;    // Register pointer, auto-increments
	logic        first_ff, nxt_first;  // Next written byte is the pointer
	logic        dir_ff,   nxt_dir;    // High for a read transfer
	logic        nack_ff,  nxt_nack;   // Host refused more read data
	logic        oe_ff,    nxt_oe;     // Pull data line low
	logic        wr_stb;               // Register write pulse
	logic [7:0]  rd_byte;

	// Register and result storage, declared early for the read mux
	lps_cfg_t    cfg_ff,   nxt_cfg;
	lps_intr_t   intr_ff,  nxt_intr;
	logic [7:0]  plow_ff, phigh_ff, lth1_ff, lth2_ff, lth3_ff;
	logic [7:0]  nxt_plow, nxt_phigh, nxt_lth1, nxt_lth2, nxt_lth3;
	logic [2:0]  span_ff,  nxt_span;
	logic [7:0]  pdata_ff, nxt_pdata;
	logic [11:0] ldata_ff, nxt_ldata;

	// Read mux; unmapped offsets read zero
	always_comb begin
		if (ptr_ff == OFS_PRODUCT_IDENTIFICATION) begin
			rd_byte = PRODUCT_IDENTIFICATION;
		end else if (ptr_ff == OFS_CONFIG) begin
			rd_byte = cfg_ff & WMASK_CONFIG;
		end else if (ptr_ff == OFS_INTERRUPT) begin
			rd_byte = intr_ff;
		end else if (ptr_ff == OFS_PROX_LOW) begin
			rd_byte = plow_ff;
		end else if (ptr_ff == OFS_PROX_HIGH) begin
			rd_byte = phigh_ff;
		end else if (ptr_ff == OFS_LTH_LOW) begin
			rd_byte = lth1_ff;
		end else if (ptr_ff == OFS_LTH_MID) begin
			rd_byte = lth2_ff;
		end else if (ptr_ff == OFS_LTH_HIGH) begin
			rd_byte = lth3_ff;
		end else if (ptr_ff == OFS_PROX_DATA) begin
			rd_byte = pdata_ff;
		end else if (ptr_ff == OFS_LIGHT_LO) begin
			rd_byte = ldata_ff[7:0];
		end else if (ptr_ff == OFS_LIGHT_HI) begin
			rd_byte = {4'h0, ldata_ff[11:8]};
		end else if (ptr_ff == OFS_SPAN) begin
			rd_byte = {5'h00, span_ff};
		end else begin
			rd_byte = 8'h00;
		end
	end

	// Serial target: sample on SCL rise, drive on SCL fall
	always_comb begin
		nxt_st    = st_ff;
		nxt_shift = shift_ff;
		nxt_bits  = bits_ff;
		nxt_ptr   = ptr_ff;
		nxt_first = first_ff;
		nxt_dir   = dir_ff;
		nxt_nack  = nack_ff;
		nxt_oe    = oe_ff;
		wr_stb    = 1'h0;
		if (bus_start) begin
			// Start or repeated start restarts address phase
			nxt_st   = ST_ADDR;
			nxt_bits = 4'h0;
			nxt_oe   = 1'h0;
		end else if (bus_stop) begin
			nxt_st = ST_IDLE;
			nxt_oe = 1'h0;
		end else begin
			case (st_ff)
				ST_ADDR, ST_WDATA: begin
					if (scl_rise) begin
						nxt_shift = {shift_ff[6:0], sda_s};
						nxt_bits  = 4'(bits_ff + 4'h1);
					end else if (scl_fall && bits_ff == 4'h8) begin
						if (st_ff == ST_WDATA) begin
							nxt_oe = 1'h1;
							nxt_st = ST_WACK;
							if (first_ff) begin
								nxt_ptr   = shift_ff;
								nxt_first = 1'h0;
							end else begin
								// Write uses the old pointer this cycle
								wr_stb  = 1'h1;
								nxt_ptr = 8'(ptr_ff + 8'h01);
							end
						end else if (shift_ff[7:1] == BUS_ADDR7) begin
							nxt_oe  = 1'h1;
							nxt_dir = shift_ff[0];
							nxt_st  = ST_AACK;
						end else begin
							nxt_st = ST_IDLE;
						end
					end
				end
				ST_AACK, ST_WACK: begin
					if (scl_fall) begin
						nxt_bits = 4'h0;
						if (st_ff == ST_WACK) begin
							nxt_oe  = 1'h0;
							nxt_st  = ST_WDATA;
						end else if (dir_ff == DIR_READ) begin
							// Present bit 7 of the addressed register
							nxt_shift = rd_byte;
							nxt_oe    = !rd_byte[7];
							nxt_bits  = 4'h1;
							nxt_ptr   = 8'(ptr_ff + 8'h01);
							nxt_st    = ST_RDATA;
						end else begin
							nxt_oe    = 1'h0;
							nxt_first = 1'h1;
							nxt_st    = ST_WDATA;
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bits_ff == 4'h8) begin
							nxt_oe = 1'h0;
							nxt_st = ST_RACK;
						end else begin
							nxt_shift = {shift_ff[6:0], 1'h0};
							nxt_oe    = !shift_ff[6];
							nxt_bits  = 4'(bits_ff + 4'h1);
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						nxt_nack = sda_s;
					end else if (scl_fall) begin
						if (nack_ff) begin
							nxt_st = ST_IDLE;
						end else begin
							nxt_shift = rd_byte;
							nxt_oe    = !rd_byte[7];
							nxt_bits  = 4'h1;
							nxt_ptr   = 8'(ptr_ff + 8'h01);
							nxt_st    = ST_RDATA;
						end
					end
				end
				default: nxt_st = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_ff     <= ST_IDLE;
			shift_ff  <= 8'h00;
			bits_ff   <= 4'h0;
			ptr_ff    <= 8'h00;
			first_ff  <= 1'h0;
			dir_ff    <= 1'h0;
			nack_ff   <= 1'h0;
			oe_ff     <= 1'h0;
		end else begin
			st_ff     <= nxt_st;
			shift_ff  <= nxt_shift;
			bits_ff   <= nxt_bits;
			ptr_ff    <= nxt_ptr;
			first_ff  <= nxt_first;
			dir_ff    <= nxt_dir;
			nack_ff   <= nxt_nack;
			oe_ff     <= nxt_oe;
		end
	end

	// Conversion timers
	typedef enum logic [2:0] {
		PX_OFF   = 3'b001,
		PX_CONV  = 3'b010,
		PX_SLEEP = 3'b100
	} lps_px_st_t;

	lps_px_st_t  px_ff,   nxt_px;
	logic [31:0] pcnt_ff, nxt_pcnt;   // Proximity phase counter
	logic [31:0] lcnt_ff, nxt_lcnt;   // Light conversion counter
	logic        light_done, prox_done;
	logic [31:0] gap_cyc;

	// Light runs back to back; proximity alternates pulse and gap
	always_comb begin
		gap_cyc    = 32'(32'(gap_units(cfg_ff.sleep_sel)) * SLEEP_CYC);
		nxt_lcnt   = 32'h0;
		light_done = 1'h0;
		nxt_px     = px_ff;
		nxt_pcnt   = 32'(pcnt_ff + 32'h1);
		prox_done  = 1'h0;
		if (cfg_ff.light_en) begin
			light_done = (lcnt_ff == 32'(LIGHT_CYC - 1));
			nxt_lcnt   = light_done ? 32'h0 : 32'(lcnt_ff + 32'h1);
		end
		case (px_ff)
			PX_CONV: begin
				if (pcnt_ff == 32'(PROX_CYC - 1)) begin
					prox_done = 1'h1;
					nxt_pcnt  = 32'h0;
					// Code 111 runs continuously with no gap
					nxt_px    = (gap_cyc == 32'h0) ? PX_CONV : PX_SLEEP;
				end
			end
			PX_SLEEP: begin
				if (pcnt_ff >= 32'(gap_cyc - 32'h1)) begin
					nxt_pcnt = 32'h0;
					nxt_px   = PX_CONV;
				end
			end
			default: begin
				nxt_pcnt = 32'h0;
				nxt_px   = PX_CONV;
			end
		endcase
		if (!cfg_ff.prox_en) begin
			nxt_px   = PX_OFF;
			nxt_pcnt = 32'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			px_ff   <= PX_OFF;
			pcnt_ff <= 32'h0;
			lcnt_ff <= 32'h0;
		end else begin
			px_ff   <= nxt_px;
			pcnt_ff <= nxt_pcnt;
			lcnt_ff <= nxt_lcnt;
		end
	end

	// Results, thresholds, persistence and flags
	logic [11:0] light_val, light_lo, light_hi;
	logic [7:0]  prox_val;
	logic [4:0]  lpers_ff, ppers_ff, nxt_lpers, nxt_ppers;
	logic        light_trip, prox_trip, nxt_alert;

	always_comb begin
		// Clamp raw front-end values to full scale
		light_val = (light_raw > 16'(LIGHT_FS)) ? LIGHT_FS
			: light_raw[11:0];
		prox_val  = (prox_raw > 10'(PROX_FS)) ? PROX_FS
			: prox_raw[7:0];
		light_lo  = {lth2_ff[3:0], lth1_ff};
		light_hi  = {lth3_ff, lth2_ff[7:4]};
		light_trip = light_val < light_lo || light_val > light_hi;
		prox_trip  = prox_val < plow_ff || prox_val > phigh_ff;
		nxt_cfg   = cfg_ff;
		nxt_intr  = intr_ff;
		nxt_plow  = plow_ff;
		nxt_phigh = phigh_ff;
		nxt_lth1  = lth1_ff;
		nxt_lth2  = lth2_ff;
		nxt_lth3  = lth3_ff;
		nxt_span  = span_ff;
		nxt_pdata = pdata_ff;
		nxt_ldata = ldata_ff;
		nxt_lpers = lpers_ff;
		nxt_ppers = ppers_ff;
		// Host writes; identity and result offsets ignore writes
		if (wr_stb) begin
			if (ptr_ff == OFS_CONFIG) begin
				nxt_cfg = shift_ff & WMASK_CONFIG;
			end else if (ptr_ff == OFS_INTERRUPT) begin
				nxt_intr = (intr_ff & ~WMASK_INTR)
					| (shift_ff & WMASK_INTR);
				// Writing zero clears a flag, one leaves it
				nxt_intr.prox_flag  = intr_ff.prox_flag
					& shift_ff[POS_PROX_FLAG];
				nxt_intr.light_flag = intr_ff.light_flag
					& shift_ff[POS_LIGHT_FLAG];
			end else if (ptr_ff == OFS_PROX_LOW) begin
				nxt_plow = shift_ff;
			end else if (ptr_ff == OFS_PROX_HIGH) begin
				nxt_phigh = shift_ff;
			end else if (ptr_ff == OFS_LTH_LOW) begin
				nxt_lth1 = shift_ff;
			end else if (ptr_ff == OFS_LTH_MID) begin
				nxt_lth2 = shift_ff;
			end else if (ptr_ff == OFS_LTH_HIGH) begin
				nxt_lth3 = shift_ff;
			end else if (ptr_ff == OFS_SPAN) begin
				nxt_span = 3'(shift_ff & WMASK_SPAN);
			end
		end
		// Conversion ends; a new event beats a same-cycle clear
		if (light_done) begin
			nxt_ldata = light_val;
			nxt_lpers = pers_next(light_trip, lpers_ff);
			if (nxt_lpers >= need_trips(intr_ff.light_pers)) begin
				nxt_intr.light_flag = 1'h1;
			end
		end
		if (prox_done) begin
			nxt_pdata = prox_val;
			nxt_ppers = pers_next(prox_trip, ppers_ff);
			if (nxt_ppers >= need_trips(intr_ff.prox_pers)) begin
				nxt_intr.prox_flag = 1'h1;
			end
		end
		// Alert pulls low on OR or AND of the two flags
		nxt_alert = intr_ff.combine
			? (intr_ff.prox_flag && intr_ff.light_flag)
			: (intr_ff.prox_flag || intr_ff.light_flag);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cfg_ff          <= RST_CONFIG;
			intr_ff         <= RST_INTERRUPT;
			plow_ff         <= RST_PROX_LOW;
			phigh_ff        <= RST_PROX_HIGH;
			lth1_ff         <= RST_LTH_LOW;
			lth2_ff         <= RST_LTH_MID;
			lth3_ff         <= RST_LTH_HIGH;
			span_ff         <= 3'h0;
			pdata_ff        <= RST_ZERO;
			ldata_ff        <= 12'h000;
			lpers_ff        <= 5'h00;
			ppers_ff        <= 5'h00;
			alert_line_n_oe <= 1'h0;
		end else begin
			cfg_ff          <= nxt_cfg;
			intr_ff         <= nxt_intr;
			plow_ff         <= nxt_plow;
			phigh_ff        <= nxt_phigh;
			lth1_ff         <= nxt_lth1;
			lth2_ff         <= nxt_lth2;
			lth3_ff         <= nxt_lth3;
			span_ff         <= nxt_span;
			pdata_ff        <= nxt_pdata;
			ldata_ff        <= nxt_ldata;
			lpers_ff        <= nxt_lpers;
			ppers_ff        <= nxt_ppers;
			alert_line_n_oe <= nxt_alert;
		end
	end

	// Drive pin leaves reset at the config default, so it never
	// moves without a host write
	localparam lps_cfg_t CFG_AT_RST = RST_CONFIG;

	// Pin and front-end outputs, all registered
	always_ff @(posedge mclk) begin
		if (srst) begin
			sda_o                <= 1'h0;
			sda_oe               <= 1'h0;
			alert_line_n_o       <= 1'h0;
			light_span_select    <= 3'h0;
			emitter_drive_select <= CFG_AT_RST.drive_sel;
			emitter_pulse        <= 1'h0;
		end else begin
			sda_o                <= 1'h0;  // Open drain: only ever low
			sda_oe               <= oe_ff;
			alert_line_n_o       <= 1'h0;
			light_span_select    <= span_ff;
			emitter_drive_select <= cfg_ff.drive_sel;
			emitter_pulse        <= (px_ff == PX_CONV);
		end
	end
endmodule : lps_sensor_regs
`default_nettype wire

/* File: common/lps_pkg.sv */
// Purpose: Shared constants and types for the light/proximity register block
// Assumes: 125 MHz mclk, 8-bit registers behind a fixed-address serial target
// Notes:   Timing counts derive from the typical times and the clock rate
`default_nettype none
package lps_pkg;
	// Bus target address (7-bit) and the read/write direction bit
	localparam logic [6:0] BUS_ADDR7 = 7'h44;
	localparam logic       DIR_READ  = 1'h1;

	// Register offsets
	localparam logic [7:0] OFS_PRODUCT_IDENTIFICATION = 8'h00;
	localparam logic [7:0] OFS_CONFIG     = 8'h01;
	localparam logic [7:0] OFS_INTERRUPT  = 8'h02;
	localparam logic [7:0] OFS_PROX_LOW   = 8'h03;
	localparam logic [7:0] OFS_PROX_HIGH  = 8'h04;
	localparam logic [7:0] OFS_LTH_LOW    = 8'h05;
	localparam logic [7:0] OFS_LTH_MID    = 8'h06;
	localparam logic [7:0] OFS_LTH_HIGH   = 8'h07;
	localparam logic [7:0] OFS_PROX_DATA  = 8'h08;
	localparam logic [7:0] OFS_LIGHT_LO   = 8'h09;
	localparam logic [7:0] OFS_LIGHT_HI   = 8'h0a;
	localparam logic [7:0] OFS_SPAN       = 8'h0b;

	// Reset values
	localparam logic [7:0] RST_CONFIG    = 8'hbc;
	localparam logic [7:0] RST_INTERRUPT = 8'h8b;
	localparam logic [7:0] RST_PROX_LOW  = 8'h00;
	localparam logic [7:0] RST_PROX_HIGH = 8'hff;
	localparam logic [7:0] RST_LTH_LOW   = 8'h00;
	localparam logic [7:0] RST_LTH_MID   = 8'hf0;
	localparam logic [7:0] RST_LTH_HIGH  = 8'hff;
	localparam logic [7:0] RST_ZERO      = 8'h00;

	// Writable bit masks; other bits read as zero or are flags
	localparam logic [7:0] WMASK_CONFIG = 8'hfc;
	localparam logic [7:0] WMASK_INTR   = 8'h67;
	localparam logic [7:0] WMASK_SPAN   = 8'h07;

	// Field positions inside the interrupt register
	localparam int POS_PROX_FLAG  = 7;
	localparam int POS_LIGHT_FLAG = 3;

	// Identity byte; the value is arbitrary
	localparam logic [7:0] PRODUCT_IDENTIFICATION_DEF = 8'h5a;

	// Full-scale counts
	localparam logic [11:0] LIGHT_FS = 12'hfff;
	localparam logic [7:0]  PROX_FS  = 8'hff;

	// Timing: times in microseconds, counts in mclk cycles
	localparam int CLK_MHZ        = 125;
	localparam int LIGHT_CONV_US  = 100000;
	localparam int PROX_CONV_US   = 800;
	localparam int SLEEP_UNIT_US  = 12500;
	localparam int LIGHT_CONV_CYC = LIGHT_CONV_US * CLK_MHZ;
	localparam int PROX_CONV_CYC  = PROX_CONV_US * CLK_MHZ;
	localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_US * CLK_MHZ;

	// Configuration register layout
	typedef struct packed {
		logic       prox_en;
		logic [2:0] sleep_sel;
		logic       drive_sel;
		logic       light_en;
		logic [1:0] unused;
	} lps_cfg_t;

	// Interrupt register layout
	typedef struct packed {
		logic       prox_flag;
		logic [1:0] prox_pers;
		logic       unused;
		logic       light_flag;
		logic [1:0] light_pers;
		logic       combine;
	} lps_intr_t;
endpackage : lps_pkg
`default_nettype wire

/* File: tb/lps_host_model.sv */
// Purpose: Bus master model standing in for the host controller
// Assumes: Pins change just after a falling mclk edge
// Notes:   Clock phases of QTR mclk cycles, above the 8-cycle floor
`timescale 1ns/1ps
`default_nettype none
module lps_host_model
	import lps_pkg::*;
#(
	parameter int QTR = 10
) (
	// Clock
	input  wire logic mclk,
	// Bus pins
	output var  logic scl,
	output var  logic sda_pull,
	input  wire logic sda
);
	logic [7:0] rdata [12]; // Bytes of the last burst read

	// Idle bus: clock high, data left to its pull-up
	initial begin
		scl      = 1'h1;
		sda_pull = 1'h0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask : tick

	// Start or repeated start: data falls while clock is high
	task automatic start_cond();
		sda_pull = 1'h0;
		tick(QTR);
		scl = 1'h1;
		tick(QTR);
		sda_pull = 1'h1;
		tick(QTR);
		scl = 1'h0;
		tick(QTR);
	endtask : start_cond

	// Stop: data rises while clock is high
	task automatic stop_cond();
		sda_pull = 1'h1;
		tick(QTR);
		scl = 1'h1;
		tick(QTR);
		sda_pull = 1'h0;
		tick(QTR);
	endtask : stop_cond

	// Data moves 2 cycles after the clock falls, so the target's
	// synchronisers always see the clock edge first
	task automatic bit_io(input logic b, output logic r);
		sda_pull = ~b;
		tick(QTR);
		scl = 1'h1;
		tick(QTR);
		r = sda;
		tick(QTR);
		scl = 1'h0;
		tick(2);
	endtask : bit_io

	// Eight bits out, then the acknowledge slot
	task automatic byte_io(input logic [7:0] d, input logic ack_in,
			output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ack_in, ack);
	endtask : byte_io

	// Single write; nak high if any byte went unanswered
	task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr,
			input logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic       a0, a1, a2;
		start_cond();
		byte_io({dev, ~DIR_READ}, 1'h1, q, a0);
		byte_io(ptr, 1'h1, q, a1);
		byte_io(d, 1'h1, q, a2);
		stop_cond();
		nak = a0 | a1 | a2;
	endtask : wr_reg

	// Burst read from ptr; the last byte is not acknowledged
	task automatic rd_regs(input logic [7:0] ptr, input int n);
		logic [7:0] q;
		logic       a;
		start_cond();
		byte_io({BUS_ADDR7, ~DIR_READ}, 1'h1, q, a);
		byte_io(ptr, 1'h1, q, a);
		start_cond();
		byte_io({BUS_ADDR7, DIR_READ}, 1'h1, q, a);
		for (int i = 0; i < n; i++) begin
			byte_io(8'hff, (i == n - 1), rdata[i], a);
		end
		stop_cond();
	endtask : rd_regs
endmodule : lps_host_model
`default_nettype wire

/* File: tb/lps_sensor_regs_sva.sv */
// Purpose: Pin-level checks for the light/proximity register block
// Assumes: Bound to every instance of lps_sensor_regs
// Notes:   Register contents are judged by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module lps_sensor_regs_sva
	import lps_pkg::*;
#(
	parameter int PROX_CYC = PROX_CONV_CYC
) (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       srst,
	// Bus and alert pins
	input wire logic       scl_i,
	input wire logic       sda_o,
	input wire logic       sda_oe,
	input wire logic       alert_line_n_o,
	input wire logic       alert_line_n_oe,
	// Front-end controls
	input wire logic [2:0] light_span_select,
	input wire logic       emitter_drive_select,
	input wire logic       emitter_pulse
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	logic [31:0] pulse_len_ff;  // Cycles the emitter has been on
	logic [31:0] nxt_pulse_len; // Next count

	// Count emitter-on cycles, restart when it goes off
	always_comb begin
		nxt_pulse_len = emitter_pulse ? pulse_len_ff + 32'h1 : 32'h0;
	end
	always_ff @(posedge mclk) begin
		pulse_len_ff <= srst ? 32'h0 : nxt_pulse_len;
	end

	sequence s_scl_held;
		scl_i ##1 scl_i;
	endsequence
	sequence s_alert_drop;
		alert_line_n_oe ##1 !alert_line_n_oe;
	endsequence

	property p_sda_open; sda_o == 1'h0; endproperty
	property p_rst_quiet; $fell(srst) |-> !sda_oe; endproperty
	property p_ack_low; $changed(sda_oe) |-> !scl_i; endproperty
	property p_hold_high; s_scl_held |-> $stable(sda_oe); endproperty
	property p_alert_open; alert_line_n_o == 1'h0; endproperty
	// Flags are sticky, so the line only releases on a host write
	property p_flag_sticky; s_alert_drop |-> !scl_i; endproperty
	property p_ctrl_write;
		$changed(light_span_select) || $changed(emitter_drive_select)
			|-> !scl_i;
	endproperty
	property p_pulse_len;
		$fell(emitter_pulse) |-> pulse_len_ff == PROX_CYC;
	endproperty

	a_sda_open: assert property (p_sda_open)
		else $error("data pin driven high");
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("data pin pulled at reset release");
	a_ack_low: assert property (p_ack_low)
		else $error("data pin moved while clock high");
	a_hold_high: assert property (p_hold_high)
		else $error("data pin not held over clock high");
	a_alert_open: assert property (p_alert_open)
		else $error("alert pin driven high");
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("alert released without a host write");
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("front-end control changed outside a write");
	a_pulse_len: assert property (p_pulse_len)
		else $error("emitter pulse length wrong");
endmodule : lps_sensor_regs_sva

bind lps_sensor_regs lps_sensor_regs_sva #(.PROX_CYC(PROX_CYC)) u_sva (
	.mclk(mclk), .srst(srst), .scl_i(scl_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .alert_line_n_o(alert_line_n_o),
	.alert_line_n_oe(alert_line_n_oe),
	.light_span_select(light_span_select),
	.emitter_drive_select(emitter_drive_select),
	.emitter_pulse(emitter_pulse)
);
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the light/proximity register block
// Assumes: Host model drives the bus; raw samples come from here
// Notes:   Short conversion counts keep the run near thirty-five thousand cycles
`timescale 1ns/1ps
`default_nettype none
module tb
	import lps_pkg::*;
;
	localparam int         LCYC = 200;   // Light conversion cycles
	localparam int         PCYC = 20;    // Proximity conversion cycles
	localparam int         SCYC = 10;    // Sleep unit cycles
	localparam logic [7:0] ID   = 8'h3c; // Identity byte, arbitrary value

	logic        mclk, srst, scl, host_pull, sda_o, sda_oe, nak;
	logic        alert_o, alert_oe, drive, pulse;
	logic [15:0] light_raw;
	logic [9:0]  prox_raw;
	logic [2:0]  span;
	int          fail_count = 0;
	int          compares   = 0;
	// Both lines have pull-ups: released means high
	wire sda          = ~(host_pull | (sda_oe & ~sda_o));
	wire alert_line_n = ~(alert_oe & ~alert_o);

	always #4 mclk = ~mclk;

	lps_sensor_regs #(.LIGHT_CYC(LCYC), .PROX_CYC(PCYC), .SLEEP_CYC(SCYC),
		.PRODUCT_IDENTIFICATION(ID)) uut (
		.mclk(mclk), .srst(srst), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .alert_line_n_o(alert_o),
		.alert_line_n_oe(alert_oe), .light_raw(light_raw),
		.prox_raw(prox_raw), .light_span_select(span),
		.emitter_drive_select(drive), .emitter_pulse(pulse));
	lps_host_model host (.mclk(mclk), .scl(scl), .sda_pull(host_pull),
		.sda(sda));

	task automatic chk(input string nm, input logic [7:0] exp,
			input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Write at our own address; the target must answer every byte
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		host.wr_reg(BUS_ADDR7, ptr, d, nak);
		chk("write ack", 8'h0, {7'h0, nak});
	endtask : wr

	task automatic rd1(input logic [7:0] p, input logic [7:0] e,
			input string nm);
		host.rd_regs(p, 1);
		chk(nm, e, host.rdata[0]);
	endtask : rd1

	// Defaults, identity byte and fresh results in one burst
	task automatic t_reset_map();
		logic [7:0] e [12];
		e = '{ID, 8'hbc, 8'h8b, 8'h00, 8'hff, 8'h00, 8'hf0, 8'hff,
			8'h5a, 8'hbc, 8'h0a, 8'h00};
		host.rd_regs(OFS_PRODUCT_IDENTIFICATION, 12);
		for (int i = 0; i < 12; i++) begin
			chk("map", e[i], host.rdata[i]);
		end
		chk("drive pin", 8'h1, {7'h0, drive});
		chk("alert reset", 8'h0, {7'h0, alert_line_n});
	endtask : t_reset_map

	// Raw values above full scale must clamp
	task automatic t_saturate();
		light_raw = 16'hffff;
		prox_raw  = 10'h3ff;
		host.tick(2 * LCYC);
		host.rd_regs(OFS_PROX_DATA, 3);
		chk("prox count", 8'hff, host.rdata[0]);
		chk("light low", 8'hff, host.rdata[1]);
		chk("light high", 8'h0f, host.rdata[2]);
	endtask : t_saturate

	// Only three range bits stored; ranges 0 to 4 reach the pins
	task automatic t_span();
		wr(OFS_SPAN, 8'hff);
		rd1(OFS_SPAN, 8'h07, "span reg");
		for (int k = 0; k < 5; k++) begin
			wr(OFS_SPAN, 8'(k));
			chk("span pins", 8'(k), {5'h0, span});
		end
	endtask : t_span

	// Foreign address, identity write and an unmapped read
	task automatic t_refuse();
		host.wr_reg(7'h45, OFS_SPAN, 8'h01, nak);
		chk("foreign nak", 8'h1, {7'h0, nak});
		rd1(OFS_SPAN, 8'h04, "span kept");
		wr(OFS_PRODUCT_IDENTIFICATION, 8'h00);
		rd1(OFS_PRODUCT_IDENTIFICATION, ID, "identity");
		rd1(8'h0c, 8'h00, "unmapped");
	endtask : t_refuse

	// Light disabled keeps the old result; enabling resumes updates
	task automatic t_light_off();
		wr(OFS_CONFIG, 8'hb0);
		chk("drive off", 8'h0, {7'h0, drive});
		light_raw = 16'h0123;
		host.tick(2 * LCYC);
		rd1(OFS_LIGHT_LO, 8'hff, "light held");
		wr(OFS_CONFIG, 8'hbc);
		host.tick(2 * LCYC);
		rd1(OFS_LIGHT_LO, 8'h23, "light new");
		rd1(OFS_LIGHT_HI, 8'h01, "light nibble");
	endtask : t_light_off

	// Sleep code 110: one gap unit after each pulse; count the duty
	// over whole periods so the phase does not matter
	task automatic t_sleep();
		int hi;
		hi = 0;
		wr(OFS_CONFIG, 8'hec);
		host.tick(30);
		for (int i = 0; i < 5 * (PCYC + SCYC); i++) begin
			host.tick(1);
			hi += pulse;
		end
		chk("pulse duty", 8'(5 * PCYC), 8'(hi));
		wr(OFS_CONFIG, 8'hbc);
	endtask : t_sleep

	// Sticky flags, clear by zero, OR then AND combining
	task automatic t_flags();
		wr(OFS_INTERRUPT, 8'h00);
		host.tick(50);
		chk("alert clear", 8'h1, {7'h0, alert_line_n});
		wr(OFS_PROX_HIGH, 8'h10);
		host.tick(150);
		chk("alert or", 8'h0, {7'h0, alert_line_n});
		rd1(OFS_INTERRUPT, 8'h80, "prox flag");
		wr(OFS_INTERRUPT, 8'h81);
		chk("alert and", 8'h1, {7'h0, alert_line_n});
		wr(OFS_LTH_MID, 8'h02);
		host.tick(2 * LCYC);
		chk("alert both", 8'h0, {7'h0, alert_line_n});
		rd1(OFS_INTERRUPT, 8'h89, "both flags");
	endtask : t_flags

	task automatic end_of_test();
		if (fail_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	// Main sequence: reset for two cycles, then every scenario
	initial begin
		mclk      = 1'h0;
		srst      = 1'h1;
		light_raw = 16'h0abc;
		prox_raw  = 10'h05a;
		repeat (2) @(negedge mclk);
		srst = 1'h0;
		host.tick(2 * LCYC);
		t_reset_map();
		t_saturate();
		t_span();
		t_refuse();
		t_light_off();
		t_sleep();
		t_flags();
		end_of_test();
	end

	// Watchdog, about 1.7 times the expected run
	initial begin
		repeat (60000) @(posedge mclk);
		fail_count++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire
